// [verilog/cog_defines.vh]
// Purpose: Constants for the clock output generator block
// Assumes: 8-bit special function register bus inside the core
// Notes:   Offsets are special function register addresses
`ifndef COG_DEFINES_VH
`define COG_DEFINES_VH

`define COG_CFG_ADDR     8'h8f
`define COG_PORT_ADDR    8'hb6
`define COG_REG_RESET    8'h00
`define COG_CLR_BIT      7
`define COG_INV_BIT      6
`define COG_SYM_BIT      5
`define COG_DIV_MSB      4
`define COG_DIV_LSB      0
`define COG_IRQ1_ANY_BIT 7
`define COG_IRQ0_ANY_BIT 6
`define COG_PIN6_BIT     5
`define COG_PIN4_BIT     4
`define COG_EN_BIT       3
`define COG_REFEN_BIT    2
`define COG_RSVD_MASK    8'hfc
`define COG_DIV_PASS     5'h01
`define COG_CNT_ONE      5'h01
`define COG_CNT_ZERO     5'h00

`endif

// [verilog/cog_clock_output_generator.v]
// Purpose: Divided clock output, pin routing and external interrupt edge select
// Assumes: ref_clk is the internal 24 MHz oscillator; SFR access is synchronous
// Notes:   Clock output is gated logic on divider flops and ~ref_clk; one period counts in ref_clk cycles
// How it works
// - Interrupt 1 edge bit: 0 one edge with configured polarity, 1 any edge.
// - Interrupt 0 edge bit works the same way for interrupt 0.
// - Pin-select bit 0 routes clock to GPIO[4], bit 1 to GPIO[6].
// - Pin routing follows only pin-select bits; enable gates only the waveform.
// - Clearing enable finishes the current period, then holds clock at 0.
// - Reference-input enable forces GPIO[3] to input, overriding port registers.
// - Clock derives from the 24 MHz oscillator, ignoring system clock divider.
// - Divider ratio spans 1 to 31 in steps of one.
// - Without clear, a new ratio is adopted only when the running period completes.
// - Writing 1 to clear resets the divider and forces the clock to 0.
// - Reading clear returns idle: 1 idle, 0 while a period runs.
// - Clear plus new ratio in one write switches to the ratio at once.
// - Inverter is the last stage; disabled output rests at invert value.
// - Inversion changes apply immediately and may glitch the output.
// - Symmetry option keeps 1:1 duty even for odd ratios.
// - Division field 0 or 1 passes the inverted oscillator (~ref_clk) through undivided.
// - Symmetry set combines two flops for near half duty cycle.
// - Symmetry clear and odd ratio: low part one cycle shorter.
`timescale 1ns/1ps
`include "cog_defines.vh"

module cog_clock_output_generator (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       irq0_pin,
  input  wire       irq1_pin,
  input  wire       irq0_polarity,
  input  wire       irq1_polarity,
  output reg        irq0_event,
  output reg        irq1_event,
  output wire       clk_out,
  output wire       gpio4_clk_select,
  output wire       gpio6_clk_select,
  output wire       gpio3_ref_input,
  output wire       gpio3_ref_clk
);

  // Register state
  reg  [7:0] cfg_reg;
  reg  [7:0] port_reg;
  reg  [4:0] div_reg;
  reg  [4:0] cnt_reg;
  reg        phase_reg;
  reg        sym_reg;
  reg        busy_reg;
  reg        gen_reg;
  reg        half_reg;
  reg        irq0_last_reg;
  reg        irq1_last_reg;
  reg  [4:0] div_next;
  reg  [4:0] cnt_next;
  reg        phase_next;
  reg        busy_next;
  reg        gen_next;
  reg        half_next;

  wire       cfg_wr   = sfr_wr && (sfr_addr == `COG_CFG_ADDR);
  wire       port_wr  = sfr_wr && (sfr_addr == `COG_PORT_ADDR);
  wire       clr_wr   = cfg_wr && sfr_wdata[`COG_CLR_BIT];
  wire       gen_en   = port_reg[`COG_EN_BIT];
  wire [4:0] div_fld  = cfg_reg[`COG_DIV_MSB:`COG_DIV_LSB];
  wire       inv      = cfg_reg[`COG_INV_BIT];
  wire       sym      = cfg_reg[`COG_SYM_BIT];

  // Effective ratio: 0 and 1 mean pass-through
  function pass_thru;
    input [4:0] d;
    begin
      pass_thru = (d <= `COG_DIV_PASS);
    end
  endfunction

  // Edge detect for an interrupt pin under edge-select and polarity
  function edge_hit;
    input cur;
    input last;
    input any_edge;
    input neg;
    begin
      if (any_edge) begin
        edge_hit = cur ^ last;
      end else if (neg) begin
        edge_hit = last & ~cur;
      end else begin
        edge_hit = cur & ~last;
      end
    end
  endfunction

  // Register writes; clear bit is write-only strobe, stored as zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg  <= `COG_REG_RESET;
      port_reg <= `COG_REG_RESET;
    end else begin
      if (cfg_wr) begin
        cfg_reg <= {1'b0, sfr_wdata[6:0]};
      end
      if (port_wr) begin
        port_reg <= sfr_wdata & `COG_RSVD_MASK;
      end
    end
  end

  // Divider next-state
  always @* begin
    div_next   = div_reg;
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    busy_next  = busy_reg;
    gen_next   = gen_reg;
    half_next  = half_reg;
    if (clr_wr) begin
      // Reset divider, force output low, take new ratio now
      cnt_next   = `COG_CNT_ZERO;
      phase_next = 1'b0;
      busy_next  = 1'b0;
      gen_next   = 1'b0;
      half_next  = 1'b0;
      div_next   = sfr_wdata[`COG_DIV_MSB:`COG_DIV_LSB];
    end else if (!busy_reg) begin
      // Idle: ratio is loaded only between periods
      div_next   = div_fld;
      phase_next = 1'b0;
      half_next  = 1'b0;
      if (gen_en) begin
        busy_next = 1'b1;
        cnt_next  = `COG_CNT_ONE;
        gen_next  = 1'b1;
        if (pass_thru(div_fld)) begin
          phase_next = 1'b1;
        end
      end
    end else if (pass_thru(div_reg)) begin
      // Undivided: period is one ref_clk cycle
      busy_next  = 1'b0;
      phase_next = 1'b0;
      if (gen_en) begin
        div_next   = div_fld;
        phase_next = pass_thru(div_fld);
        busy_next  = 1'b1;
        cnt_next   = `COG_CNT_ONE;
      end
    end else begin
      // Low part first: floor(d/2) cycles, then high part
      cnt_next = cnt_reg + `COG_CNT_ONE;
      if (cnt_reg == (div_reg >> 1)) begin
        phase_next = 1'b1;
      end
      if (cnt_reg == div_reg) begin
        // Period boundary
        phase_next = 1'b0;
        busy_next  = 1'b0;
        cnt_next   = `COG_CNT_ZERO;
        if (gen_en) begin
          div_next   = div_fld;
          busy_next  = 1'b1;
          cnt_next   = `COG_CNT_ONE;
          phase_next = pass_thru(div_fld);
        end
      end
    end
  end

  // Divider state, clocked by the oscillator only
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg   <= `COG_CNT_ZERO;
      cnt_reg   <= `COG_CNT_ZERO;
      phase_reg <= 1'b0;
      busy_reg  <= 1'b0;
      gen_reg   <= 1'b0;
      half_reg  <= 1'b0;
    end else begin
      div_reg   <= div_next;
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      busy_reg  <= busy_next;
      gen_reg   <= gen_next;
      half_reg  <= half_next;
    end
  end

  // Falling-edge copy delays the rising edge of the high part by half a cycle
  always @(negedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sym_reg <= 1'b0;
    end else begin
      sym_reg <= phase_reg;
    end
  end

  // Symmetric mode ANDs both flops for odd ratios: the high part loses half a
  // cycle, the low part gains it, so both halves are d/2 cycles; inverter last
  wire odd_div  = div_reg[0] && !pass_thru(div_reg);
  wire sym_mix  = (sym && odd_div) ? (phase_reg & sym_reg) : phase_reg;
  wire pass_clk = phase_reg & ~ref_clk;
  wire raw_clk  = pass_thru(div_reg) ? pass_clk : sym_mix;
  assign clk_out = raw_clk ^ inv;

  // Pin routing depends only on pin-select bits
  assign gpio4_clk_select = port_reg[`COG_PIN4_BIT];
  assign gpio6_clk_select = port_reg[`COG_PIN6_BIT];
  assign gpio3_ref_input  = port_reg[`COG_REFEN_BIT];
  assign gpio3_ref_clk    = port_reg[`COG_REFEN_BIT] & irq0_pin ^ irq0_pin & 1'b0;

  // External interrupt edge detection
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq0_last_reg <= 1'b0;
      irq1_last_reg <= 1'b0;
      irq0_event    <= 1'b0;
      irq1_event    <= 1'b0;
    end else begin
      irq0_last_reg <= irq0_pin;
      irq1_last_reg <= irq1_pin;
      irq0_event    <= edge_hit(irq0_pin, irq0_last_reg,
                                port_reg[`COG_IRQ0_ANY_BIT], irq0_polarity);
      irq1_event    <= edge_hit(irq1_pin, irq1_last_reg,
                                port_reg[`COG_IRQ1_ANY_BIT], irq1_polarity);
    end
  end

  // Read mux; clear bit reads as idle status
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= `COG_REG_RESET;
    end else if (sfr_rd) begin
      if (sfr_addr == `COG_CFG_ADDR) begin
        sfr_rdata <= {~busy_reg, cfg_reg[6:0]};
      end else if (sfr_addr == `COG_PORT_ADDR) begin
        sfr_rdata <= port_reg;
      end else begin
        sfr_rdata <= `COG_REG_RESET;
      end
    end
  end

endmodule // cog_clock_output_generator

// [test/cog_sink.sv]
// Purpose: External chip fed by the generated clock
// Assumes: Samples clk_out on ref_clk rising edge
// Notes:   Reports the last high and low run lengths
`timescale 1ns/1ps
module cog_sink (
  input  wire       ref_clk,
  input  wire       clk_out,
  output reg  [5:0] high_len,
  output reg  [5:0] low_len
);
  reg       last = 1'b0;
  reg [5:0] run  = 6'h00;
  // Measure runs between level changes
  always @(posedge ref_clk) begin
    if (clk_out === last) run <= run + 6'h01;
    else begin
      if (last) high_len <= run;
      else low_len <= run;
      run <= 6'h01;
    end
    last <= clk_out;
  end
endmodule // cog_sink

// [test/cog_chk.sv]
// Purpose: Port checks for the clock output generator
// Assumes: Sees only the top ports
// Notes:   Mirrors registers from observed writes
`timescale 1ns/1ps
module cog_chk (
  input wire       ref_clk,
  input wire       resetn,
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       clk_out,
  input wire       gpio4_clk_select,
  input wire       gpio6_clk_select,
  input wire       gpio3_ref_input
);
  reg  [7:0] port_q;
  reg  [6:0] cfg_q;
  reg  [5:0] idle_n;
  wire       wp = sfr_wr && sfr_addr == 8'hb6;
  wire       wc = sfr_wr && sfr_addr == 8'h8f;
  wire       rp = sfr_rd && sfr_addr == 8'hb6;
  wire       rc = sfr_rd && sfr_addr == 8'h8f;
  // Register mirror and disabled-cycle count
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_q <= 8'h00;
      cfg_q  <= 7'h00;
      idle_n <= 6'h00;
    end else begin
      if (wp) port_q <= sfr_wdata & 8'hfc;
      if (wc) cfg_q <= sfr_wdata[6:0];
      if (port_q[3]) idle_n <= 6'h00;
      else if (idle_n != 6'h28) idle_n <= idle_n + 6'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_pin4_route: assert property (wp |=> gpio4_clk_select == port_q[4])
    else $error("gpio4 routing wrong");
  chk_pin6_route: assert property (wp |=> gpio6_clk_select == port_q[5])
    else $error("gpio6 routing wrong");
  chk_ref_input: assert property (wp |=> gpio3_ref_input == port_q[2])
    else $error("gpio3 input force wrong");
  chk_clear_forces: assert property (wc && sfr_wdata[7] && sfr_wdata[4:1] != 4'h0 |=> clk_out == cfg_q[6])
    else $error("clear did not force output");
  chk_idle_level: assert property (idle_n == 6'h28 |-> clk_out == cfg_q[6])
    else $error("disabled output level wrong");
  chk_idle_status: assert property (rc && idle_n == 6'h28 |=> sfr_rdata[7])
    else $error("idle status not shown");
  chk_port_read: assert property (rp |=> sfr_rdata == port_q)
    else $error("port settings read wrong");
  chk_cfg_read: assert property (rc |=> sfr_rdata[6:0] == cfg_q)
    else $error("config read wrong");
  chk_unmapped_zero: assert property (sfr_rd && !rp && !rc |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
endmodule // cog_chk
bind cog_clock_output_generator cog_chk i_cog_chk (.ref_clk, .resetn, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rd, .sfr_rdata, .clk_out, .gpio4_clk_select, .gpio6_clk_select,
  .gpio3_ref_input);

// [test/testbench.sv]
// Purpose: Self-checking bench for the clock output generator
// Assumes: 40 ns ref_clk, asynchronous active-low reset
// Notes:   Divider checks use run lengths seen by the sink
`timescale 1ns/1ps
module testbench;
  reg        ref_clk   = 1'b0;
  reg        resetn    = 1'b0;
  reg  [7:0] sfr_addr  = 8'h00;
  reg        sfr_wr    = 1'b0;
  reg  [7:0] sfr_wdata = 8'h00;
  reg        sfr_rd    = 1'b0;
  reg  [1:0] pin       = 2'h0;
  reg  [1:0] pol       = 2'h3;
  wire [7:0] sfr_rdata;
  wire [1:0] ev;
  wire       clk_out, g4, g6, g3;
  wire [5:0] hi, lo;
  integer    bad_count = 0;
  integer    checked   = 0;
  cog_clock_output_generator i_cog_clock_output_generator (.ref_clk, .resetn, .sfr_addr,
    .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .irq0_pin(pin[0]), .irq1_pin(pin[1]),
    .irq0_polarity(pol[0]), .irq1_polarity(pol[1]), .irq0_event(ev[0]),
    .irq1_event(ev[1]), .clk_out, .gpio4_clk_select(g4), .gpio6_clk_select(g6),
    .gpio3_ref_input(g3), .gpio3_ref_clk());
  cog_sink i_cog_sink (.ref_clk, .clk_out, .high_len(hi), .low_len(lo));
  task check(input string n, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge ref_clk);
      sfr_wr    <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e, input string n);
    begin
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge ref_clk);
      sfr_rd   <= 1'b0;
      #1;
      check(n, e, sfr_rdata & m);
    end
  endtask
  task t_route;
    begin
      rd(8'h8f, 8'hff, 8'h80, "cfg reset");
      rd(8'hb6, 8'hff, 8'h00, "port reset");
      rd(8'h90, 8'hff, 8'h00, "unmapped");
      wr(8'hb6, 8'h20);
      check("pins", 8'h04, {5'h00, g6, g4, g3});
      wr(8'hb6, 8'h38);
      check("pins", 8'h06, {5'h00, g6, g4, g3});
      wr(8'hb6, 8'h04);
      check("pins", 8'h01, {5'h00, g6, g4, g3});
      rd(8'hb6, 8'hff, 8'h04, "port");
      wr(8'hb6, 8'h00);
      cyc(40);
    end
  endtask
  task t_div(input [4:0] d, input [5:0] h, input [5:0] l);
    begin
      wr(8'h8f, {3'h0, d});
      wr(8'hb6, 8'h18);
      cyc(3 * d + 4);
      check("high run", h, hi);
      check("low run", l, lo);
      wr(8'hb6, 8'h10);
      cyc(40);
      check("idle clk", 8'h00, clk_out);
      rd(8'h8f, 8'hff, {3'h4, d}, "idle cfg");
    end
  endtask
  task t_switch;
    begin
      wr(8'h8f, 8'h1f);
      wr(8'hb6, 8'h18);
      cyc(4);
      rd(8'h8f, 8'h80, 8'h00, "busy");
      wr(8'h8f, 8'h84);
      cyc(14);
      check("clear high", 8'h02, hi);
      check("clear low", 8'h02, lo);
      wr(8'h8f, 8'h06);
      cyc(20);
      check("new high", 8'h03, hi);
      check("new low", 8'h03, lo);
      wr(8'hb6, 8'h10);
      cyc(40);
      wr(8'h8f, 8'h46);
      check("inverted idle", 8'h01, clk_out);
      wr(8'h8f, 8'h06);
    end
  endtask
  task irq_edge(input integer i, input logic v, input logic e);
    logic s;
    begin
      s = 1'b0;
      @(posedge ref_clk);
      pin[i] <= v;
      repeat (4) begin
        @(posedge ref_clk);
        s = s | ev[i];
      end
      check("irq event", {7'h00, e}, {7'h00, s});
    end
  endtask
  task t_irq;
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        wr(8'hb6, 8'h00);
        irq_edge(i, 1'b1, 1'b0);
        irq_edge(i, 1'b0, 1'b1);
        wr(8'hb6, i ? 8'h80 : 8'h40);
        irq_edge(i, 1'b1, 1'b1);
      end
      // Single rising edge polarity
      pol <= 2'h0;
      wr(8'hb6, 8'h00);
      irq_edge(0, 1'b0, 1'b0);
      irq_edge(0, 1'b1, 1'b1);
      irq_edge(1, 1'b0, 1'b0);
      irq_edge(1, 1'b1, 1'b1);
    end
  endtask
  // Odd ratio with symmetry: count high half cycles over two periods
  task t_sym;
    integer k;
    integer n;
    begin
      n = 0;
      wr(8'h8f, 8'h25);
      wr(8'hb6, 8'h18);
      cyc(12);
      for (k = 0; k < 20; k = k + 1) begin
        if (k[0]) @(posedge ref_clk);
        else @(negedge ref_clk);
        n = n + clk_out;
      end
      check("sym high halves", 8'h0a, n[7:0]);
      wr(8'hb6, 8'h10);
      cyc(40);
    end
  endtask
  task summarize;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Clock, watchdog and main sequence
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    #160000;
    bad_count = bad_count + 1;
    summarize;
  end
  initial begin
    cyc(20);
    resetn <= 1'b1;
    t_route;
    t_div(5'h02, 6'h01, 6'h01);
    t_div(5'h04, 6'h02, 6'h02);
    t_div(5'h05, 6'h03, 6'h02);
    t_div(5'h1f, 6'h10, 6'h0f);
    t_switch;
    t_sym;
    t_irq;
    summarize;
  end
endmodule // testbench
